// [logic/cbir_router.sv]
`timescale 1ns/10ps
`include "cbir_params.svh"
// ************************************************************
// Card bridge interrupt router
// ************************************************************
// Summary of operation
// - Steer card interrupt to ten ISA IRQs
// - IRQ group selectable edge or level mode
// - IRQ14 level while others stay edge
// - IRQ pins float until routing valid
// - Functional route from routing register low nibble
// - Masked events raise no interrupt
// - INTA# open drain, pulls low only
// - Interrupt line nibble routes to INTA#
// - CardBus events always signalled on INTA#
// - Two-bit field picks 16-bit signalling mode
// - Chain output ANDs own and input levels
// - Clock-run pin requests clock restart
// - INTC# is chain output, INTD# input
// - Serialized line replicates each internal IRQ
// - Packet: start, interrupt slots, stop
// - Fixed slot length, start four-to-eight
// - Slots ascend IRQ0 to channel check
// - Internal IRQs treated active high
// - Stop only after channel check slot
// - IRQ5 pin serial line, IRQ7 unused
// - Extended control selects routing and serial
// - Sources: card IREQ and status changes
// - 16-bit flags clear by read or write
module cbir_router #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk, // Bus clock, 125 MHz
  input wire logic rst_b, // System reset input, async
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_wdata, // Write data
  output logic [31:0] reg_rdata, // Read data, registered
  input wire logic card_is_cardbus, // Thirty-two-bit card present
  input wire logic [`CBIR_PIN_W-1:0] pins_i, // Raw asynchronous pins
  output logic [15:0] isa_irq_o, // ISA IRQ drive values
  output logic [15:0] isa_irq_oe_b, // Low while driving
  output logic inta_o, // INTA# drive value
  output logic inta_oe_b, // Low while pulling INTA#
  output logic serial_chain_output_o, // INTC# value
  output logic serial_chain_output_oe_b, // Low while driving INTC#
  output logic clkrun_o, // Clock-run drive value
  output logic clkrun_oe_b // Low while holding clock
);
  logic [`CBIR_PIN_W-1:0] sync_q [SYNC_STAGES];
  logic [`CBIR_PIN_W-1:0] prev_q;
  logic [7:0] func_route_q, csc_cfg_q, global_ctl_q, mode_ctl_q;
  logic [7:0] int_line_q, cb_mask_q;
  logic [31:0] ext_ctl_q;
  logic [3:0] csc_flags_q, csc_flags_d;
  logic [1:0] cb_flags_q, cb_flags_d;
  logic [15:0] isa_o_q, isa_oe_b_q, isa_o_d, isa_oe_b_d;
  logic inta_oe_b_q, chain_q, chain_oe_b_q, clkrun_oe_b_q;
  logic [31:0] rdata_q;
  logic ser_o, ser_oe_b;

  generate
    if (SYNC_STAGES < 2)
    begin : g_bad
      $error("cbir_router: SYNC_STAGES must be at least 2");
    end
  endgenerate

  function automatic logic valid_irq(input logic [3:0] n);
    valid_irq = n inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = addr == ofs;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  genvar s;
  generate
    for (s = 0; s < SYNC_STAGES; s++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b) sync_q[s] <= '1;
        else if (s == 0) sync_q[s] <= pins_i;
        else sync_q[s] <= sync_q[(s == 0) ? 0 : s - 1];
      end
    end
  endgenerate

  wire [`CBIR_PIN_W-1:0] pin_s = sync_q[SYNC_STAGES-1];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) prev_q <= '1;
    else prev_q <= pin_s;
  end

  wire [`CBIR_PIN_W-1:0] pin_chg = pin_s ^ prev_q;

  // ************************************************************
  // Register decode
  // ************************************************************
  wire wr_func = reg_wr && hit(reg_addr, `CBIR_OFS_FUNC_ROUTE);
  wire wr_stat = reg_wr && hit(reg_addr, `CBIR_OFS_CSC_STATUS);
  wire wr_cfg = reg_wr && hit(reg_addr, `CBIR_OFS_CSC_CONFIG);
  wire wr_gctl = reg_wr && hit(reg_addr, `CBIR_OFS_GLOBAL_CTL);
  wire wr_mode = reg_wr && hit(reg_addr, `CBIR_OFS_MODE_CTL);
  wire wr_line = reg_wr && hit(reg_addr, `CBIR_OFS_INT_LINE);
  wire wr_cbev = reg_wr && hit(reg_addr, `CBIR_OFS_CB_EVENT);
  wire wr_cbmk = reg_wr && hit(reg_addr, `CBIR_OFS_CB_MASK);
  wire wr_ext = reg_wr && hit(reg_addr, `CBIR_OFS_EXT_CTL1);
  wire rd_stat = reg_rd && hit(reg_addr, `CBIR_OFS_CSC_STATUS);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      func_route_q <= `CBIR_REG8_RST;
      csc_cfg_q <= `CBIR_REG8_RST;
      global_ctl_q <= `CBIR_REG8_RST;
      mode_ctl_q <= `CBIR_REG8_RST;
      int_line_q <= `CBIR_INT_LINE_RST;
      cb_mask_q <= `CBIR_REG8_RST;
      ext_ctl_q <= `CBIR_EXT_CTL1_RST;
    end
    else
    begin
      if (wr_func) func_route_q <= reg_wdata[7:0];
      if (wr_cfg) csc_cfg_q <= reg_wdata[7:0];
      if (wr_gctl) global_ctl_q <= reg_wdata[7:0];
      if (wr_mode) mode_ctl_q <= reg_wdata[7:0];
      if (wr_line) int_line_q <= reg_wdata[7:0];
      if (wr_cbmk) cb_mask_q <= reg_wdata[7:0];
      if (wr_ext) ext_ctl_q <= reg_wdata;
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  wire clr_by_write = global_ctl_q[`CBIR_CLR_BY_WRITE_BIT];
  wire is16 = !card_is_cardbus;
  wire [3:0] csc_set = {pin_chg[`CBIR_PIN_DETECT],
                        pin_chg[`CBIR_PIN_RDY_IREQ] & is16,
                        pin_chg[`CBIR_PIN_BVD2] & is16,
                        pin_chg[`CBIR_PIN_BVD1] & is16};
  wire [1:0] cb_set = {pin_chg[`CBIR_PIN_DETECT] & card_is_cardbus,
                       pin_chg[`CBIR_PIN_CSTSCHG] & pin_s[`CBIR_PIN_CSTSCHG]
                         & card_is_cardbus};
  // Read-clear only when write-clear is off; a new event still wins
  wire [3:0] csc_clr = clr_by_write ? (wr_stat ? reg_wdata[3:0] : 4'h0)
                                    : (rd_stat ? 4'hF : 4'h0);
  wire [1:0] cb_clr = wr_cbev ? reg_wdata[1:0] : 2'h0;

  assign csc_flags_d = (csc_flags_q & ~csc_clr) | csc_set;
  assign cb_flags_d = (cb_flags_q & ~cb_clr) | cb_set;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csc_flags_q <= 4'h0;
      cb_flags_q <= 2'h0;
    end
    else
    begin
      csc_flags_q <= csc_flags_d;
      cb_flags_q <= cb_flags_d;
    end
  end

  // ************************************************************
  // Routing and mode decode
  // ************************************************************
  wire [3:0] func_route = func_route_q[3:0];
  wire [3:0] csc_route = csc_cfg_q[`CBIR_CSC_ROUTE_LSB+:4];
  wire [2:0] ext_route = ext_ctl_q[`CBIR_EXT_ROUTE_LSB+:3];
  wire ext_serial = ext_ctl_q[`CBIR_EXT_SERIAL_BIT];
  wire [1:0] mode_fld = mode_ctl_q[1:0];
  wire serial_mode = (mode_fld == 2'(cbir_pkg::CBIR_MODE_SERIAL)) || ext_serial;
  wire pcpci_mode = (mode_fld == 2'(cbir_pkg::CBIR_MODE_PCPCI)) && !serial_mode;
  wire isa_mode = (mode_fld == 2'(cbir_pkg::CBIR_MODE_ISA)) && !serial_mode;
  wire level_all = mode_ctl_q[`CBIR_LEVEL_ALL_BIT];
  wire irq14_level = mode_ctl_q[`CBIR_IRQ14_LEVEL_BIT];
  wire pci_route_en = int_line_q[3:0] != 4'hF;

  wire csc_req = |(csc_flags_q & csc_cfg_q[3:0]);
  wire cint_act = !pin_s[`CBIR_PIN_CINT] && card_is_cardbus;
  wire cb_req = |(cb_flags_q & cb_mask_q[1:0])
              | (cint_act & cb_mask_q[`CBIR_CB_CINT_EN_BIT]);
  wire func_req = !pin_s[`CBIR_PIN_RDY_IREQ] && is16 && valid_irq(func_route);
  wire csc16_isa = is16 && valid_irq(csc_route);
  // CardBus sources reach the ISA IRQs only through the serialized ext_route slot
  wire inta_assert = cb_req || (csc_req && is16 && !csc16_isa && pci_route_en);
  wire [3:0] pci_slot = {1'b1, ext_route};

  logic [15:0] irq_vec;
  logic [15:0] pin_used;
  genvar n;
  generate
    for (n = 0; n < 16; n++)
    begin : g_irq
      // Internal IRQs are active high whatever the pin polarity
      assign irq_vec[n] = (func_req && func_route == 4'(n))
                        || (csc_req && csc16_isa && csc_route == 4'(n))
                        || (serial_mode && ext_route != 3'h0 && inta_assert
                            && pci_slot == 4'(n));
      assign pin_used[n] = (valid_irq(func_route) && func_route == 4'(n))
                         || (valid_irq(csc_route) && csc_route == 4'(n));
      wire lvl = level_all || (irq14_level && n == 14);
      assign isa_o_d[n] = (serial_mode && n == 5) ? ser_o
                        : (lvl ? !irq_vec[n] : irq_vec[n]);
      assign isa_oe_b_d[n] = (serial_mode && n == 5) ? ser_oe_b
                           : !(isa_mode && pin_used[n]);
    end
  endgenerate

  // ************************************************************
  // Serialized IRQ engine
  // ************************************************************
  cbir_irq_serializer u_ser (
    .clk(clk),
    .rst_b(rst_b),
    .enable(serial_mode),
    .line_s(pin_s[`CBIR_PIN_SERIAL]),
    .irq_vec(irq_vec),
    .line_o(ser_o),
    .line_oe_b(ser_oe_b),
    .frame_busy()
  );

  // ************************************************************
  // Pin outputs
  // ************************************************************
  wire own_b = !(|irq_vec);
  wire chain_d = pin_s[`CBIR_PIN_CHAIN_IN] & own_b;
  // Clock stop request seen high; pull low to keep clock for a pending IRQ
  wire clkrun_hold = pcpci_mode && !own_b && pin_s[`CBIR_PIN_CLKRUN];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      isa_o_q <= 16'h0000;
      isa_oe_b_q <= 16'hFFFF;
      inta_oe_b_q <= 1'b1;
      chain_q <= 1'b1;
      chain_oe_b_q <= 1'b1;
      clkrun_oe_b_q <= 1'b1;
    end
    else
    begin
      isa_o_q <= isa_o_d;
      isa_oe_b_q <= isa_oe_b_d;
      inta_oe_b_q <= !inta_assert;
      chain_q <= chain_d;
      chain_oe_b_q <= !pcpci_mode;
      clkrun_oe_b_q <= !clkrun_hold;
    end
  end

  assign isa_irq_o = isa_o_q;
  assign isa_irq_oe_b = isa_oe_b_q;
  assign inta_o = 1'b0;
  assign inta_oe_b = inta_oe_b_q;
  assign serial_chain_output_o = chain_q;
  assign serial_chain_output_oe_b = chain_oe_b_q;
  assign clkrun_o = 1'b0;
  assign clkrun_oe_b = clkrun_oe_b_q;

  // ************************************************************
  // Read path
  // ************************************************************
  wire [31:0] rd_mux =
      hit(reg_addr, `CBIR_OFS_FUNC_ROUTE) ? {24'h000000, func_route_q}
    : hit(reg_addr, `CBIR_OFS_CSC_STATUS) ? {28'h0000000, csc_flags_q}
    : hit(reg_addr, `CBIR_OFS_CSC_CONFIG) ? {24'h000000, csc_cfg_q}
    : hit(reg_addr, `CBIR_OFS_GLOBAL_CTL) ? {24'h000000, global_ctl_q}
    : hit(reg_addr, `CBIR_OFS_MODE_CTL) ? {24'h000000, mode_ctl_q}
    : hit(reg_addr, `CBIR_OFS_INT_LINE) ? {24'h000000, int_line_q}
    : hit(reg_addr, `CBIR_OFS_CB_EVENT) ? {30'h0000000, cb_flags_q}
    : hit(reg_addr, `CBIR_OFS_CB_MASK) ? {24'h000000, cb_mask_q}
    : hit(reg_addr, `CBIR_OFS_EXT_CTL1) ? ext_ctl_q
    : 32'h00000000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) rdata_q <= 32'h00000000;
    else if (reg_rd) rdata_q <= rd_mux;
  end

  assign reg_rdata = rdata_q;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_inta_follows;
    @(posedge clk) disable iff (!rst_b)
    inta_assert |=> !inta_oe_b;
  endproperty
  a_inta_follows: assert property (p_inta_follows) else $error("INTA# not pulled");

  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_b)
    (csc_cfg_q[3:0] == 4'h0) && (cb_mask_q[2:0] == 3'h0) |=> inta_oe_b;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked event on INTA#");

  property p_float_invalid;
    @(posedge clk) disable iff (!rst_b)
    !valid_irq(func_route) && !valid_irq(csc_route) && !serial_mode |=> &isa_irq_oe_b;
  endproperty
  a_float_invalid: assert property (p_float_invalid) else $error("IRQ pin driven early");

  property p_irq7_unused;
    @(posedge clk) disable iff (!rst_b)
    serial_mode |=> isa_irq_oe_b[7];
  endproperty
  a_irq7_unused: assert property (p_irq7_unused) else $error("IRQ7 driven serial");

  property p_chain_and;
    @(posedge clk) disable iff (!rst_b)
    pcpci_mode |=> !serial_chain_output_oe_b && (serial_chain_output_o == $past(chain_d));
  endproperty
  a_chain_and: assert property (p_chain_and) else $error("chain output wrong");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_b)
    csc_set[0] && rd_stat |=> csc_flags_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_cb_read_keeps;
    @(posedge clk) disable iff (!rst_b)
    reg_rd && !reg_wr && (cb_flags_q != 2'h0) |=> (cb_flags_q & $past(cb_flags_q)) == $past(cb_flags_q);
  endproperty
  a_cb_read_keeps: assert property (p_cb_read_keeps) else $error("CardBus flag read-cleared");

  property p_irq14_level;
    @(posedge clk) disable iff (!rst_b)
    isa_mode && irq14_level && !level_all && pin_used[14] && pin_used[3]
      |=> (isa_irq_o[14] == !$past(irq_vec[14])) && (isa_irq_o[3] == $past(irq_vec[3]));
  endproperty
  a_irq14_level: assert property (p_irq14_level) else $error("IRQ14 mix broken");
endmodule

// [pkg/cbir_params.svh]
`ifndef CBIR_PARAMS_SVH
`define CBIR_PARAMS_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define CBIR_OFS_FUNC_ROUTE 8'h03
`define CBIR_OFS_CSC_STATUS 8'h04
`define CBIR_OFS_CSC_CONFIG 8'h05
`define CBIR_OFS_GLOBAL_CTL 8'h1E
`define CBIR_OFS_MODE_CTL 8'h3B
`define CBIR_OFS_INT_LINE 8'h3C
`define CBIR_OFS_CB_EVENT 8'h40
`define CBIR_OFS_CB_MASK 8'h44
`define CBIR_OFS_EXT_CTL1 8'hD0
// ************************************************************
// Field positions and reset values
// ************************************************************
`define CBIR_CSC_ROUTE_LSB 4
`define CBIR_CLR_BY_WRITE_BIT 2
`define CBIR_LEVEL_ALL_BIT 2
`define CBIR_IRQ14_LEVEL_BIT 3
`define CBIR_EXT_ROUTE_LSB 10
`define CBIR_EXT_SERIAL_BIT 16
`define CBIR_CB_CINT_EN_BIT 2
`define CBIR_REG8_RST 8'h00
`define CBIR_INT_LINE_RST 8'hFF
`define CBIR_EXT_CTL1_RST 32'h00000000
// ************************************************************
// Pin vector layout and serial timing counts
// ************************************************************
`define CBIR_PIN_DETECT 0
`define CBIR_PIN_BVD1 1
`define CBIR_PIN_BVD2 2
`define CBIR_PIN_RDY_IREQ 3
`define CBIR_PIN_CSTSCHG 4
`define CBIR_PIN_CINT 5
`define CBIR_PIN_CHAIN_IN 6
`define CBIR_PIN_CLKRUN 7
`define CBIR_PIN_SERIAL 8
`define CBIR_PIN_W 9
`define CBIR_START_MIN_CLKS 4
`define CBIR_STOP_MIN_CLKS 2
`define CBIR_SLOT_CLKS 3
`define CBIR_SLOT_COUNT 17
`endif

// [pkg/cbir_pkg.sv]
package cbir_pkg;
  typedef enum logic [1:0] {
    CBIR_MODE_ISA,
    CBIR_MODE_PCPCI,
    CBIR_MODE_SERIAL,
    CBIR_MODE_RSVD
  } cbir_mode_e;
  typedef enum logic [1:0] {
    CBIR_SER_IDLE,
    CBIR_SER_START,
    CBIR_SER_SLOTS,
    CBIR_SER_STOP
  } cbir_ser_state_e;
endpackage

// [logic/cbir_irq_serializer.sv]
`timescale 1ns/10ps
`include "cbir_params.svh"
module cbir_irq_serializer #(
  parameter int SLOT_CLKS = `CBIR_SLOT_CLKS,
  parameter int SLOTS = `CBIR_SLOT_COUNT
) (
  input wire logic clk, // Bus clock
  input wire logic rst_b, // Async reset
  input wire logic enable, // Serialized mode on
  input wire logic line_s, // Synchronised line level
  input wire logic [15:0] irq_vec, // Internal IRQs, active high
  output logic line_o, // Line drive value
  output logic line_oe_b, // Low while driving
  output logic frame_busy // Inside start..stop
);
  cbir_pkg::cbir_ser_state_e state_q, state_d;
  logic [3:0] low_cnt_q;
  logic [4:0] slot_q;
  logic [1:0] phase_q;
  logic drive_q;

  generate
    if (SLOT_CLKS < 2 || SLOT_CLKS > 4 || SLOTS < 17 || SLOTS > 31)
    begin : g_bad
      $error("cbir_irq_serializer: unsupported slot parameters");
    end
  endgenerate

  function automatic logic slot_level(input logic [4:0] slot, input logic [15:0] vec);
    // Slot 2 is SMI and slot 16 the channel check; neither is ours
    slot_level = (slot < 5'h10) && (slot != 5'h02) && vec[slot[3:0]];
  endfunction

  wire phase_last = phase_q == 2'(SLOT_CLKS - 1);
  wire slot_last = slot_q == 5'(SLOTS - 1);
  wire start_ok = low_cnt_q >= 4'(`CBIR_START_MIN_CLKS);
  wire stop_ok = low_cnt_q >= 4'(`CBIR_STOP_MIN_CLKS);
  wire in_sample = (state_q == cbir_pkg::CBIR_SER_SLOTS) && (phase_q == 2'h0);
  wire drive_d = enable && in_sample && slot_level(slot_q, irq_vec);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cbir_pkg::CBIR_SER_IDLE:
        if (!line_s) state_d = cbir_pkg::CBIR_SER_START;
      cbir_pkg::CBIR_SER_START:
        // Start may be 4, 6 or 8 clocks; shorter lows are slot noise
        if (line_s) state_d = start_ok ? cbir_pkg::CBIR_SER_SLOTS : cbir_pkg::CBIR_SER_IDLE;
      cbir_pkg::CBIR_SER_SLOTS:
        if (phase_last && slot_last) state_d = cbir_pkg::CBIR_SER_STOP;
      cbir_pkg::CBIR_SER_STOP:
        // Host may add platform slots before stop; one-clock lows ignored
        if (line_s && stop_ok) state_d = cbir_pkg::CBIR_SER_IDLE;
    endcase
    if (!enable) state_d = cbir_pkg::CBIR_SER_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= cbir_pkg::CBIR_SER_IDLE;
      low_cnt_q <= 4'h0;
      drive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      low_cnt_q <= line_s ? 4'h0 : (low_cnt_q == 4'hF ? 4'hF : low_cnt_q + 4'h1);
      drive_q <= drive_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_q <= 5'h00;
      phase_q <= 2'h0;
    end
    else if (state_q != cbir_pkg::CBIR_SER_SLOTS)
    begin
      slot_q <= 5'h00;
      phase_q <= 2'h0;
    end
    else
    begin
      phase_q <= phase_last ? 2'h0 : phase_q + 2'h1;
      slot_q <= phase_last ? slot_q + 5'h01 : slot_q;
    end
  end

  assign line_o = 1'b0;
  assign line_oe_b = ~drive_q;
  assign frame_busy = state_q != cbir_pkg::CBIR_SER_IDLE;

  property p_drive_in_slot;
    @(posedge clk) disable iff (!rst_b)
    !line_oe_b |-> $past(in_sample);
  endproperty
  a_drive_in_slot: assert property (p_drive_in_slot) else $error("drive outside slot");

  property p_short_start;
    @(posedge clk) disable iff (!rst_b)
    (state_q == cbir_pkg::CBIR_SER_START) && line_s && !start_ok && enable
      |=> state_q == cbir_pkg::CBIR_SER_IDLE;
  endproperty
  a_short_start: assert property (p_short_start) else $error("short start taken");

  property p_slot_step;
    @(posedge clk) disable iff (!rst_b)
    (state_q == cbir_pkg::CBIR_SER_SLOTS) && phase_last && !slot_last && enable
      |=> slot_q == $past(slot_q) + 5'h01;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot order broken");
endmodule

// [sim/cbir_serial_host.sv]
`timescale 1ns/10ps
// ****
// Serialized line host
// ****
module cbir_serial_host (
  input wire logic clk, // Bus clock
  input wire logic line, // Resolved line level
  input wire logic go, // Run one frame
  input wire logic [3:0] start_len, // Start clocks
  output logic host_low, // Host pulls line low
  output logic done, // Frame over
  output int n_low, // Low samples seen
  output int first_at, // First low sample
  output int last_at // Last low sample
);
  initial
  begin
    host_low = 1'b0;
    done = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        #1;
        done = 1'b0;
        host_low = 1'b1;
        repeat (start_len) @(posedge clk);
        #1;
        host_low = 1'b0;
        n_low = 0;
        // Runs past the last slot: extra host slots must be tolerated
        for (int t = 1; t <= 60; t++)
        begin
          @(posedge clk);
          if (line === 1'b0)
          begin
            if (n_low == 0) first_at = t;
            last_at = t;
            n_low++;
          end
        end
        #1;
        host_low = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        host_low = 1'b0;
        done = 1'b1;
        wait (!go);
      end
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/10ps
`include "cbir_params.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  logic clk, rst_b, reg_wr, reg_rd, card_is_cardbus, go, host_low, done, lv, req;
  logic [7:0] reg_addr, pins;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [15:0] isa_irq_o, isa_irq_oe_b;
  logic inta_o, inta_oe_b, chain_o, chain_oe_b, ser_wire, ck_o, ck_oe_b;
  logic [3:0] start_len, r;
  int n_low, first_at, last_at, n_mismatch, cmp_count;
  localparam logic [3:0] IRQS [10] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
  // Released line floats to its pull-up
  assign ser_wire = ~host_low & (isa_irq_oe_b[5] | isa_irq_o[5]);
  cbir_router #(.SYNC_STAGES(2)) dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .card_is_cardbus(card_is_cardbus), .pins_i({ser_wire, pins}), .isa_irq_o(isa_irq_o),
    .isa_irq_oe_b(isa_irq_oe_b), .inta_o(inta_o), .inta_oe_b(inta_oe_b),
    .serial_chain_output_o(chain_o), .serial_chain_output_oe_b(chain_oe_b),
    .clkrun_o(ck_o), .clkrun_oe_b(ck_oe_b));
  cbir_serial_host host_u (.clk(clk), .line(ser_wire), .go(go), .start_len(start_len),
    .host_low(host_low), .done(done), .n_low(n_low), .first_at(first_at), .last_at(last_at));
  function automatic logic valid_irq(input logic [3:0] v);
    valid_irq = 1'b0;
    foreach (IRQS[i]) if (IRQS[i] == v) valid_irq = 1'b1;
  endfunction
  function automatic logic [15:0] exp_oe(input logic [3:0] v);
    exp_oe = valid_irq(v) ? ~(16'h0001 << v) : 16'hFFFF;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    rdv = reg_rdata;
  endtask
  // Covers sync and output latency of the pin paths
  task idle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task frame(input logic [3:0] s);
    int k;
    start_len = s;
    go = 1'b1;
    @(posedge clk);
    #2;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clk);
    #1;
    go = 1'b0;
    // Host must see go low on an edge before the next frame
    @(posedge clk);
    #1;
    if (k == 200)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    {rst_b, reg_wr, reg_rd, card_is_cardbus, go} = 5'h00;
    {reg_addr, reg_wdata, start_len} = '0;
    {n_mismatch, cmp_count} = '0;
    // Idle pins: no request, no event, chain input high
    pins = 8'hEF;
    void'($urandom(32'h52E028F8));
    repeat (20) @(posedge clk);
    `CHK({inta_oe_b, isa_irq_oe_b}, 17'h1FFFF);
    #1;
    rst_b = 1'b1;
    wr(`CBIR_OFS_EXT_CTL1, 32'h00011C00);
    rd(`CBIR_OFS_EXT_CTL1);
    `CHK(rdv, 32'h00011C00);
    wr(`CBIR_OFS_EXT_CTL1, 32'h0);
    rd(`CBIR_OFS_INT_LINE);
    `CHK(rdv, 32'hFF);
    rd(`CBIR_OFS_MODE_CTL);
    `CHK(rdv, 32'h0);
    rd(8'h80);
    `CHK(rdv, 32'h0);
    // ****
    // Parallel ISA routing, all ten pins then random
    // ****
    for (int i = 0; i < 16; i++)
    begin
      r = (i < 10) ? IRQS[i] : 4'($urandom_range(15, 0));
      lv = 1'($urandom_range(1, 0));
      req = 1'($urandom_range(1, 0));
      wr(`CBIR_OFS_MODE_CTL, {29'h0, lv, 2'h0});
      wr(`CBIR_OFS_FUNC_ROUTE, {28'h0, r});
      pins[3] = ~req;
      idle();
      `CHK(isa_irq_oe_b, exp_oe(r));
      if (valid_irq(r)) `CHK(isa_irq_o[r], req ^ lv);
    end
    wr(`CBIR_OFS_MODE_CTL, 32'h03);
    idle();
    `CHK(isa_irq_oe_b, 16'hFFFF);
    pins[3] = 1'b0;
    // IRQ3 held by the status route while IRQ14 carries the card
    wr(`CBIR_OFS_CSC_CONFIG, 32'h30);
    wr(`CBIR_OFS_MODE_CTL, 32'h08);
    for (int i = 0; i < 2; i++)
    begin
      r = i ? 4'h3 : 4'hE;
      wr(`CBIR_OFS_FUNC_ROUTE, {28'h0, r});
      idle();
      `CHK(isa_irq_o[r], r != 4'hE);
    end
    // ****
    // Chain and serialized modes
    // ****
    wr(`CBIR_OFS_MODE_CTL, 32'h01);
    wr(`CBIR_OFS_FUNC_ROUTE, 32'h9);
    for (int k = 0; k < 4; k++)
    begin
      pins[6] = k[1];
      pins[3] = ~k[0];
      idle();
      `CHK(chain_o, k[1] & ~k[0]);
      `CHK({ck_o, ck_oe_b}, {1'b0, ~k[0]});
      `CHK({chain_oe_b, isa_irq_oe_b}, 17'h0FFFF);
    end
    wr(`CBIR_OFS_MODE_CTL, 32'h02);
    wr(`CBIR_OFS_CSC_CONFIG, 32'h38);
    pins[0] = 1'b0;
    idle();
    for (int s = 4; s <= 8; s += 2)
    begin
      frame(4'(s));
      `CHK(n_low, 2);
      `CHK(last_at - first_at, 18);
      `CHK(isa_irq_oe_b[7], 1'b1);
    end
    // Status read lands on the edge that sees this change: set must win
    pins[1] = ~pins[1];
    @(posedge clk);
    rd(`CBIR_OFS_CSC_STATUS);
    `CHK(rdv & 32'h8, 32'h8);
    rd(`CBIR_OFS_CSC_STATUS);
    `CHK(rdv & 32'h9, 32'h1);
    frame(4'h6);
    `CHK(n_low, 1);
    // Too short a start is no frame
    frame(4'h2);
    `CHK(n_low, 0);
    // ****
    // INTA routing, 16-bit events then CardBus
    // ****
    wr(`CBIR_OFS_MODE_CTL, 32'h0);
    wr(`CBIR_OFS_CSC_CONFIG, 32'h08);
    wr(`CBIR_OFS_INT_LINE, 32'h0A);
    pins[0] = 1'b1;
    idle();
    `CHK(inta_oe_b, 1'b0);
    rd(`CBIR_OFS_CSC_STATUS);
    idle();
    `CHK(inta_oe_b, 1'b1);
    card_is_cardbus = 1'b1;
    wr(`CBIR_OFS_FUNC_ROUTE, 32'h0);
    wr(`CBIR_OFS_MODE_CTL, 32'h02);
    pins[4] = 1'b1;
    idle();
    `CHK(inta_oe_b, 1'b1);
    wr(`CBIR_OFS_CB_MASK, 32'h1);
    idle();
    `CHK({inta_o, inta_oe_b}, 2'b00);
    rd(`CBIR_OFS_CB_EVENT);
    `CHK(rdv, 32'h1);
    wr(`CBIR_OFS_CB_EVENT, 32'h3);
    idle();
    `CHK(inta_oe_b, 1'b1);
    pins[5] = 1'b0;
    wr(`CBIR_OFS_CB_MASK, 32'h4);
    idle();
    `CHK(inta_oe_b, 1'b0);
    give_verdict();
  end
endmodule
